//--- hw/ahxc_host_xfer_control.sv
// Host port transfer mode, pin and busy control with local register port
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "ahxc_defines.svh"

module ahxc_host_xfer_control #(
    parameter int DATA_W = 16
) (
    // Clock, reset, enable
    input  wire logic               core_clk,
    input  wire logic               rst,
    input  wire logic               ce,
    // Local register port
    input  wire logic [7:0]         reg_addr,
    input  wire logic [7:0]         reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic      [7:0]         reg_rdata,
    // Host bus inputs
    input  wire logic [2:0]         host_addr,
    input  wire logic [1:0]         host_cs_n,
    input  wire logic               host_read_strobe_n,
    input  wire logic               host_write_strobe_n,
    input  wire logic [DATA_W-1:0]  host_data_in,
    input  wire logic               host_reset,
    // Status and sequencer inputs
    input  wire logic               ram_xfer_busy,
    input  wire logic               auto_packet_active,
    input  wire logic               data_xfer_trigger,
    input  wire logic               auto_packet_start,
    input  wire logic               fifo_data_ready,
    // Data routing
    output logic                    packet_fifo_push,
    output logic                    data_port_push,
    output logic      [DATA_W-1:0]  host_word,
    // Mode outputs
    output ahxc_pkg::ahxc_proto_t   xfer_protocol,
    output ahxc_pkg::ahxc_mode_t    xfer_mode,
    output logic      [1:0]         ultra_timing_field,
    output logic                    atapi_bsy,
    // Open-drain pins, enable low while driving
    output logic                    diag_pin_o,
    output logic                    diag_pin_oe_n,
    output logic                    drive_active_pin_o,
    output logic                    drive_active_pin_oe_n,
    output logic                    iordy_o,
    output logic                    iordy_oe_n,
    output logic                    iocs16_o,
    output logic                    iocs16_oe_n
);

    if (DATA_W != 16) begin : g_bad_width
        $error("ahxc_host_xfer_control: host words are 16 bits");
    end

    // Register state
    logic [7:0]              mode_ctrl;
    logic [7:0]              pin_ctrl;
    logic [2:0]              drive_active_sel;
    logic                    auto_mode_from_feature;
    logic [1:0]              utim;
    ahxc_pkg::ahxc_haddr_t   latched_addr;

    // Strobe edges
    logic                    rd_fall;
    logic                    wr_fall;
    logic                    wr_rise;

    ahxc_edge_detect #(
        .W (1)
    ) u_rd_edge (
        .core_clk (core_clk),
        .rst      (rst),
        .ce       (ce),
        .level    (host_read_strobe_n),
        .fall     (rd_fall),
        .rise     ()
    );

    ahxc_edge_detect #(
        .W (1)
    ) u_wr_edge (
        .core_clk (core_clk),
        .rst      (rst),
        .ce       (ce),
        .level    (host_write_strobe_n),
        .fall     (wr_fall),
        .rise     (wr_rise)
    );

    // Field views
    wire addr_latch_enable        = mode_ctrl[`AHXC_MODE_ADDR_LATCH_ENABLE];
    wire bit_pio     = mode_ctrl[`AHXC_MODE_PIO];
    wire bit_mdma    = mode_ctrl[`AHXC_MODE_MDMA];
    wire bit_udma    = mode_ctrl[`AHXC_MODE_UDMA];
    wire bit_dir     = mode_ctrl[`AHXC_MODE_DIR];
    wire diag_en     = pin_ctrl[`AHXC_PIN_DIAG];
    wire dasp_en     = pin_ctrl[`AHXC_PIN_DASP];
    wire clr_cmd     = pin_ctrl[`AHXC_PIN_BUSY_CLEAR_CMD];
    wire set_cmd     = pin_ctrl[`AHXC_PIN_BUSY_SET_CMD];
    wire cod         = pin_ctrl[`AHXC_PIN_COD];
    wire rdy_en      = pin_ctrl[`AHXC_PIN_RDY];
    wire wide_en     = pin_ctrl[`AHXC_PIN_WIDE];

    // Address seen by the host decode: latched copy or live pins
    ahxc_pkg::ahxc_haddr_t live_addr;
    ahxc_pkg::ahxc_haddr_t eff_addr;
    assign live_addr.addr = host_addr;
    assign live_addr.cs_n = host_cs_n;
    assign eff_addr       = addr_latch_enable ? latched_addr : live_addr;

    wire strobe_fall   = rd_fall | wr_fall;
    wire cmd_blk       = (eff_addr.cs_n == `AHXC_CS_CMD_BLK);
    wire ctl_blk       = (eff_addr.cs_n == `AHXC_CS_CTL_BLK);
    wire sel_data      = cmd_blk && (eff_addr.addr == `AHXC_HREG_DATA);
    wire sel_feat      = cmd_blk && (eff_addr.addr == `AHXC_HREG_FEAT);
    wire sel_cmd       = cmd_blk && (eff_addr.addr == `AHXC_HREG_CMD);
    wire sel_devctl    = ctl_blk && (eff_addr.addr == `AHXC_HREG_DEVCTL);

    // Host write completes on the rising strobe edge
    wire host_data_wr  = wr_rise && sel_data;
    wire host_feat_wr  = wr_rise && sel_feat;
    wire diag_cmd      = wr_rise && sel_cmd
                         && (host_data_in[7:0] == `AHXC_CMD_DIAG);
    wire soft_reset    = wr_rise && sel_devctl
                         && host_data_in[`AHXC_SRST_BIT];
    wire pin_release   = diag_cmd || soft_reset || host_reset;

    // Local register decode
    wire wr_mode  = reg_wr && (reg_addr == `AHXC_OFF_MODE);
    wire wr_pin   = reg_wr && (reg_addr == `AHXC_OFF_PIN);
    wire wr_dsel  = reg_wr && (reg_addr == `AHXC_OFF_DASP_SEL);
    wire wr_auto  = reg_wr && (reg_addr == `AHXC_OFF_AUTO);
    wire wr_utim  = reg_wr && (reg_addr == `AHXC_OFF_UTIM);

    // Busy commands act only while no packet reception runs
    wire clr_go   = clr_cmd && !auto_packet_active;
    wire set_go   = set_cmd && !auto_packet_active;

    // Next value of the mode register; bits 7 to 5, busy status included, are never stored
    logic [7:0] next_mode_ctrl;
    always_comb begin
        next_mode_ctrl = mode_ctrl;
        if (wr_mode) begin
            next_mode_ctrl = reg_wdata & 8'h1f;
        end
        if (host_feat_wr && auto_mode_from_feature) begin
            next_mode_ctrl[`AHXC_MODE_PIO] = host_data_in[0];
        end
    end

    // Next value of the pin and busy register
    logic [7:0] next_pin_ctrl;
    always_comb begin
        next_pin_ctrl = pin_ctrl;
        if (wr_pin) begin
            next_pin_ctrl = reg_wdata & 8'h7f;
        end else begin
            // Self-clear only when the command has taken effect
            if (clr_cmd && !atapi_bsy) begin
                next_pin_ctrl[`AHXC_PIN_BUSY_CLEAR_CMD] = 1'b0;
            end
            if (set_cmd && atapi_bsy) begin
                next_pin_ctrl[`AHXC_PIN_BUSY_SET_CMD] = 1'b0;
            end
        end
        // Sequencer updates outrank a firmware write in the same cycle
        if (auto_packet_start) begin
            next_pin_ctrl[`AHXC_PIN_COD] = 1'b1;
        end
        if (data_xfer_trigger && !bit_pio) begin
            next_pin_ctrl[`AHXC_PIN_COD] = bit_dir;
        end
        // Pin releases act like a reset and so win over firmware
        if (pin_release) begin
            next_pin_ctrl[`AHXC_PIN_DIAG] = 1'b0;
            next_pin_ctrl[`AHXC_PIN_DASP] = 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            mode_ctrl <= `AHXC_MODE_RST;
            pin_ctrl  <= `AHXC_PIN_RST;
        end else if (ce) begin
            mode_ctrl <= next_mode_ctrl;
            pin_ctrl  <= next_pin_ctrl;
        end
    end

    // Auxiliary control registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            drive_active_sel       <= 3'h0;
            auto_mode_from_feature <= 1'b0;
            utim                   <= 2'h0;
        end else if (ce) begin
            if (wr_dsel) begin
                drive_active_sel <= reg_wdata[2:0];
            end
            if (wr_auto) begin
                auto_mode_from_feature <= reg_wdata[`AHXC_AUTO_MODE];
            end
            if (wr_utim) begin
                utim <= reg_wdata[`AHXC_UTIM_HI:`AHXC_UTIM_LO];
            end
        end
    end

    // Address latch; feature bit 0 reaches the mode register PIO bit only while auto mode is set
    always_ff @(posedge core_clk) begin
        if (rst) begin
            latched_addr <= '1;
        end else if (ce) begin
            if (addr_latch_enable && strobe_fall) begin
                latched_addr <= live_addr;
            end
        end
    end

    // BSY flag; a pending clear wins over a pending set in the same cycle
    always_ff @(posedge core_clk) begin
        if (rst) begin
            atapi_bsy <= 1'b0;
        end else if (ce) begin
            if (clr_go) begin
                atapi_bsy <= 1'b0;
            end else if (set_go) begin
                atapi_bsy <= 1'b1;
            end
        end
    end

    // Host data words, routed by the packet select
    always_ff @(posedge core_clk) begin
        if (rst) begin
            packet_fifo_push <= 1'b0;
            data_port_push   <= 1'b0;
            host_word        <= '0;
        end else if (ce) begin
            packet_fifo_push <= host_data_wr && cod;
            data_port_push   <= host_data_wr && !cod;
            if (host_data_wr) begin
                host_word <= host_data_in;
            end
        end else begin
            packet_fifo_push <= 1'b0;
            data_port_push   <= 1'b0;
        end
    end

    // Protocol select: PIO first, then Ultra DMA, then multiword DMA
    assign xfer_protocol = bit_pio  ? ahxc_pkg::AHXC_PROTO_PIO :
                           bit_udma ? ahxc_pkg::AHXC_PROTO_UDMA :
                           bit_mdma ? ahxc_pkg::AHXC_PROTO_MDMA :
                                      ahxc_pkg::AHXC_PROTO_SDMA;
    assign xfer_mode.mdma     = bit_mdma;
    assign xfer_mode.pio      = bit_pio;
    assign xfer_mode.dir      = bit_dir;
    assign xfer_mode.udma     = bit_udma;
    assign ultra_timing_field = utim;

    // Open-drain pins; each only ever pulls low
    wire dasp_on  = dasp_en || (|drive_active_sel);
    wire rd_data  = !host_read_strobe_n && sel_data;
    wire stretch  = rdy_en && rd_data && !fifo_data_ready;
    wire wide_on  = wide_en && sel_data
                    && !(host_read_strobe_n && host_write_strobe_n);

    assign diag_pin_o            = 1'b0;
    assign diag_pin_oe_n         = !diag_en;
    assign drive_active_pin_o    = 1'b0;
    assign drive_active_pin_oe_n = !dasp_on;
    assign iordy_o               = 1'b0;
    assign iordy_oe_n            = !stretch;
    assign iocs16_o              = 1'b0;
    assign iocs16_oe_n           = !wide_on;

    // Read mux; unmapped offsets return zero
    wire [7:0] stat_word = {ram_xfer_busy, 3'h0, bit_mdma, bit_pio,
                            bit_dir, bit_udma};
    logic [7:0] next_rdata;
    always_comb begin
        next_rdata = 8'h00;
        unique case (reg_addr)
            `AHXC_OFF_MODE:     next_rdata = stat_word;
            `AHXC_OFF_PIN:      next_rdata = pin_ctrl;
            `AHXC_OFF_DASP_SEL: next_rdata = {5'h00, drive_active_sel};
            `AHXC_OFF_AUTO:     next_rdata = {auto_mode_from_feature, 7'h00};
            `AHXC_OFF_UTIM:     next_rdata = {2'h0, utim, 4'h0};
            default:            next_rdata = 8'h00;
        endcase
    end

    // Read data stand for exactly the cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (ce && reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    sequence s_clr_pending;
        ce && clr_cmd && !auto_packet_active && !wr_pin;
    endsequence

    sequence s_clr_done;
        !atapi_bsy ##1 (!clr_cmd || !$past(ce && !wr_pin));
    endsequence

    chk_reset_pin_value: assert property ($past(rst) |-> pin_ctrl == 8'h26 && mode_ctrl == 8'h00)
        else $error("pin control or mode register wrong after reset");
    chk_status_mirror: assert property (ce && reg_rd && reg_addr == 8'h1f |=> reg_rdata == {$past(ram_xfer_busy), 3'h0, $past(mode_ctrl[3:0])})
        else $error("status read does not mirror busy and mode bits");
    chk_pio_wins: assert property (mode_ctrl[2] |-> xfer_protocol == ahxc_pkg::AHXC_PROTO_PIO)
        else $error("PIO bit set but protocol is not PIO");
    chk_mdma_gated: assert property (mode_ctrl[3:2] == 2'b10 && !mode_ctrl[0] |-> xfer_protocol == ahxc_pkg::AHXC_PROTO_MDMA)
        else $error("multiword DMA not chosen with PIO off");
    chk_diag_release: assert property (ce && pin_release |=> diag_pin_oe_n && !pin_ctrl[5])
        else $error("diag or drive active enable survived a release event");
    chk_busy_clear: assert property (s_clr_pending |=> s_clr_done)
        else $error("clear busy did not drop BSY and self clear");
    chk_busy_blocked: assert property (ce && auto_packet_active && !rst |=> atapi_bsy == $past(atapi_bsy))
        else $error("BSY moved during packet reception");
    chk_cod_trigger: assert property (ce && data_xfer_trigger && !mode_ctrl[2] && !pin_release |=> pin_ctrl[2] == $past(mode_ctrl[1]))
        else $error("packet select not set from direction on DMA trigger");
    chk_fifo_route: assert property (ce && host_data_wr && cod |=> packet_fifo_push && !data_port_push && host_word == $past(host_data_in))
        else $error("host data word not routed to packet FIFO");
    chk_iordy_gate: assert property (!pin_ctrl[1] |-> iordy_oe_n)
        else $error("IORDY driven while its enable is clear");
    chk_addr_latch: assert property (ce && mode_ctrl[4] && strobe_fall |=> latched_addr == $past(live_addr))
        else $error("host address not latched on strobe fall");

endmodule

`default_nettype wire

//--- hw/ahxc_defines.svh
// Register offsets, field positions and reset values of the host port block
`ifndef AHXC_DEFINES_SVH
`define AHXC_DEFINES_SVH

// Local register offsets
`define AHXC_OFF_MODE      8'h1f
`define AHXC_OFF_PIN       8'h20
`define AHXC_OFF_DASP_SEL  8'h3f
`define AHXC_OFF_AUTO      8'h5b
`define AHXC_OFF_UTIM      8'h8a

// Transfer mode control and status fields
`define AHXC_MODE_UDMA     0
`define AHXC_MODE_DIR      1
`define AHXC_MODE_PIO      2
`define AHXC_MODE_MDMA     3
`define AHXC_MODE_ADDR_LATCH_ENABLE     4
`define AHXC_STAT_RBUSY    7
`define AHXC_MODE_RST      8'h00

// Pin and busy control fields
`define AHXC_PIN_WIDE      0
`define AHXC_PIN_RDY       1
`define AHXC_PIN_COD       2
`define AHXC_PIN_BUSY_SET_CMD    3
`define AHXC_PIN_BUSY_CLEAR_CMD    4
`define AHXC_PIN_DASP      5
`define AHXC_PIN_DIAG      6
`define AHXC_PIN_RST       8'h26

// Auxiliary fields
`define AHXC_AUTO_MODE     7
`define AHXC_UTIM_LO       4
`define AHXC_UTIM_HI       5

// Host task file decode
`define AHXC_HREG_DATA     3'h0
`define AHXC_HREG_FEAT     3'h1
`define AHXC_HREG_DEVCTL   3'h6
`define AHXC_HREG_CMD      3'h7
`define AHXC_CS_CMD_BLK    2'b10
`define AHXC_CS_CTL_BLK    2'b01
`define AHXC_SRST_BIT      2
`define AHXC_CMD_DIAG      8'h90

`endif

//--- hw/ahxc_pkg.sv
// Types shared by the host transfer control block
package ahxc_pkg;

    // Protocol actually used on the host data path
    typedef enum logic [1:0] {
        AHXC_PROTO_SDMA = 2'b00,
        AHXC_PROTO_MDMA = 2'b01,
        AHXC_PROTO_UDMA = 2'b10,
        AHXC_PROTO_PIO  = 2'b11
    } ahxc_proto_t;

    // Host address and chip selects, travel together
    typedef struct packed {
        logic [2:0] addr;
        logic [1:0] cs_n;
    } ahxc_haddr_t;

    // Mode bits mirrored in the status register
    typedef struct packed {
        logic mdma;
        logic pio;
        logic dir;
        logic udma;
    } ahxc_mode_t;

endpackage

//--- hw/ahxc_edge_detect.sv
// Edge detector for synchronous host strobes
`timescale 1ns/1ps
`default_nettype none

module ahxc_edge_detect #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst,
    input  wire logic         ce,
    // Level in, edges out
    input  wire logic [W-1:0] level,
    output logic      [W-1:0] fall,
    output logic      [W-1:0] rise
);

    logic [W-1:0] prev;

    // Elaboration check, a zero-wide detector serves nothing
    if (W < 1) begin : g_bad_width
        $error("ahxc_edge_detect: W must be at least 1");
    end

    // Strobes idle high, so reset to the idle level
    always_ff @(posedge core_clk) begin
        if (rst) begin
            prev <= '1;
        end else if (ce) begin
            prev <= level;
        end
    end

    assign fall = prev & ~level;
    assign rise = ~prev & level;

endmodule

`default_nettype wire

//--- bench/ahxc_host_model.sv
// Host adapter model driving the IDE side of the transfer control block
`timescale 1ns/1ps
`default_nettype none

module ahxc_host_model (
    // Clock
    input  wire logic        core_clk,
    // Host bus
    output logic      [2:0]  host_addr,
    output logic      [1:0]  host_cs_n,
    output logic             host_read_strobe_n,
    output logic             host_write_strobe_n,
    output logic      [15:0] host_data_in,
    output logic             host_reset
);
    initial begin
        host_addr           = 3'h0;
        host_cs_n           = 2'b11;
        host_read_strobe_n  = 1'b1;
        host_write_strobe_n = 1'b1;
        host_data_in        = 16'h5a5a;
        host_reset          = 1'b0;
    end

    // Strobe falls with address and selects
    task automatic lo(input logic rd, input logic [1:0] cs,
                      input logic [2:0] a);
        @(posedge core_clk);
        host_cs_n <= cs;
        host_addr <= a;
        if (rd) host_read_strobe_n <= 1'b0;
        else host_write_strobe_n <= 1'b0;
    endtask

    // Address moves while the strobe is low, to probe the latch
    task automatic move(input logic [1:0] cs, input logic [2:0] a);
        @(posedge core_clk);
        host_cs_n <= cs;
        host_addr <= a;
    endtask

    // Rising strobe carries a whole word; then the line is let go
    task automatic hi(input logic [15:0] d);
        @(posedge core_clk);
        host_read_strobe_n  <= 1'b1;
        host_write_strobe_n <= 1'b1;
        host_data_in        <= d;
        @(posedge core_clk);
        host_data_in <= ~d;
        host_cs_n    <= 2'b11;
    endtask

    task automatic wr(input logic [1:0] cs, input logic [2:0] a,
                      input logic [15:0] d);
        lo(1'b0, cs, a);
        hi(d);
    endtask

    task automatic pulse_reset();
        @(posedge core_clk);
        host_reset <= 1'b1;
        @(posedge core_clk);
        host_reset <= 1'b0;
    endtask
endmodule

`default_nettype wire

//--- bench/tb.sv
// Self-checking bench for the host transfer control block
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic core_clk, rst, ce, reg_wr, reg_rd;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, n_pk, n_dp;
    logic [2:0] host_addr;
    logic [1:0] host_cs_n, ultra_timing_field;
    logic host_read_strobe_n, host_write_strobe_n, host_reset;
    logic [15:0] host_data_in, host_word;
    logic ram_xfer_busy, auto_packet_active, data_xfer_trigger;
    logic auto_packet_start, fifo_data_ready, atapi_bsy;
    logic packet_fifo_push, data_port_push;
    logic diag_pin_oe_n, drive_active_pin_oe_n, iordy_oe_n, iocs16_oe_n;
    ahxc_pkg::ahxc_proto_t xfer_protocol;
    ahxc_pkg::ahxc_mode_t  xfer_mode;
    logic [31:0] rnd;
    logic [7:0]  v;
    int          num_errors, n_checks;

    ahxc_host_model host (.core_clk, .host_addr, .host_cs_n,
        .host_read_strobe_n, .host_write_strobe_n, .host_data_in,
        .host_reset);

    ahxc_host_xfer_control DUT (.core_clk, .rst, .ce, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .host_addr, .host_cs_n,
        .host_read_strobe_n, .host_write_strobe_n, .host_data_in,
        .host_reset, .ram_xfer_busy, .auto_packet_active,
        .data_xfer_trigger, .auto_packet_start, .fifo_data_ready,
        .packet_fifo_push, .data_port_push, .host_word, .xfer_protocol,
        .xfer_mode, .ultra_timing_field, .atapi_bsy, .diag_pin_o(),
        .diag_pin_oe_n, .drive_active_pin_o(), .drive_active_pin_oe_n,
        .iordy_o(), .iordy_oe_n, .iocs16_o(), .iocs16_oe_n);

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        n_pk <= n_pk + packet_fifo_push;
        n_dp <= n_dp + data_port_push;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic ahxc_pkg::ahxc_proto_t exp_proto(input logic [7:0] m);
        if (m[2]) return ahxc_pkg::AHXC_PROTO_PIO;
        if (m[0]) return ahxc_pkg::AHXC_PROTO_UDMA;
        if (m[3]) return ahxc_pkg::AHXC_PROTO_MDMA;
        return ahxc_pkg::AHXC_PROTO_SDMA;
    endfunction

    task automatic chk(input logic [15:0] g, input logic [15:0] e,
                       input string m);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
        end
    endtask

    task automatic rg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rg_rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, e, "register read");
    endtask

    // Host data port write, pushes counted over a short window
    task automatic xfer(input logic split, input logic [15:0] d,
                        input logic [7:0] ep, input logic [7:0] ed);
        #1;
        n_pk = 8'h00;
        n_dp = 8'h00;
        host.lo(1'b0, 2'b10, 3'h0);
        if (split) host.move(2'b11, 3'h3);
        host.hi(d);
        repeat (3) @(posedge core_clk);
        #1;
        chk(n_pk, ep, "packet pushes");
        chk(n_dp, ed, "data pushes");
    endtask

    task automatic pulse(input logic dma);
        @(posedge core_clk);
        if (dma) data_xfer_trigger <= 1'b1;
        else auto_packet_start <= 1'b1;
        @(posedge core_clk);
        data_xfer_trigger <= 1'b0;
        auto_packet_start <= 1'b0;
    endtask

    task automatic wrap_up();
        if (num_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        num_errors++;
        wrap_up();
    end

    initial begin
        logic [7:0] tbl [6] = '{8'h0c, 8'h0e, 8'h08, 8'h0a, 8'h09, 8'h0b};
        logic [7:0] bsy [4] = '{8'h08, 8'h10, 8'h10, 8'h08};
        logic [7:0] tm [3] = '{8'h02, 8'h00, 8'h06};
        logic [7:0] tc [3] = '{8'h06, 8'h02, 8'h02};
        {rst, ce, reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b11, 18'h0};
        {ram_xfer_busy, auto_packet_active, data_xfer_trigger} = 3'b000;
        {auto_packet_start, fifo_data_ready, n_pk, n_dp} = 18'h10000;
        rnd = 32'hc68c;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        #1;
        chk(drive_active_pin_oe_n, 1'b0, "drive active at reset");
        chk(diag_pin_oe_n, 1'b1, "diag at reset");
        rg_rd(8'h20, 8'h26);
        rg_rd(8'h1f, 8'h00);
        for (int i = 0; i < 16; i++) begin
            rnd = lfsr(rnd);
            v = (i < 6) ? tbl[i] : rnd[7:0];
            if (v[0]) v[3] = 1'b0;
            @(posedge core_clk);
            ram_xfer_busy <= rnd[8];
            rg_wr(8'h1f, v);
            rg_wr(8'h8a, rnd[15:8]);
            rg_rd(8'h1f, {rnd[8], 3'h0, v[3:0]});
            chk(xfer_mode, v[3:0], "mode bits");
            chk(xfer_protocol, exp_proto(v), "protocol");
            chk(ultra_timing_field, rnd[13:12], "ultra timing");
        end
        rg_wr(8'h40, 8'hff);
        rg_rd(8'h40, 8'h00);
        rg_rd(8'h20, 8'h26);
        for (int i = 0; i < 3; i++) begin
            rg_wr(8'h20, 8'h66);
            @(posedge core_clk);
            #1;
            chk(diag_pin_oe_n, 1'b0, "diag driven");
            if (i == 0) host.wr(2'b10, 3'h7, 16'h0090);
            else if (i == 1) host.wr(2'b01, 3'h6, 16'h0004);
            else host.pulse_reset();
            if (i == 1) host.wr(2'b01, 3'h6, 16'h0000);
            #1;
            chk(diag_pin_oe_n, 1'b1, "diag released");
            chk(drive_active_pin_oe_n, 1'b1, "dasp released");
            rg_rd(8'h20, 8'h06);
        end
        for (int k = 0; k < 4; k++) begin
            rg_wr(8'h3f, (k < 3) ? (8'h01 << k) : 8'h00);
            #1;
            chk(drive_active_pin_oe_n, k == 3, "dasp select");
        end
        @(posedge core_clk);
        ce <= 1'b0;
        rg_wr(8'h20, 8'h66);
        @(posedge core_clk);
        ce <= 1'b1;
        rg_rd(8'h20, 8'h06);
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            auto_packet_active <= i[0];
            rg_wr(8'h20, 8'h06 | bsy[i]);
            repeat (3) @(posedge core_clk);
            #1;
            chk(atapi_bsy, i < 2, "busy flag");
            if (i[0]) rg_wr(8'h20, 8'h06);
            else rg_rd(8'h20, 8'h06);
        end
        auto_packet_active <= 1'b0;
        rnd = lfsr(rnd);
        xfer(1'b0, rnd[15:0], 8'h01, 8'h00);
        chk(host_word, rnd[15:0], "host word");
        rg_wr(8'h20, 8'h02);
        xfer(1'b0, ~rnd[15:0], 8'h00, 8'h01);
        chk(host_word, ~rnd[15:0], "host word");
        rg_wr(8'h1f, 8'h14);
        xfer(1'b1, rnd[31:16], 8'h00, 8'h01);
        rg_wr(8'h1f, 8'h04);
        xfer(1'b1, rnd[31:16], 8'h00, 8'h00);
        for (int i = 0; i < 3; i++) begin
            rg_wr(8'h1f, tm[i]);
            pulse(1'b1);
            rg_rd(8'h20, tc[i]);
        end
        pulse(1'b0);
        rg_rd(8'h20, 8'h06);
        for (int j = 0; j < 2; j++) begin
            rg_wr(8'h20, j ? 8'h00 : 8'h03);
            host.lo(1'b1, 2'b10, 3'h0);
            fifo_data_ready <= 1'b0;
            @(posedge core_clk);
            #1;
            chk(iocs16_oe_n, j, "iocs16");
            chk(iordy_oe_n, j, "iordy");
            @(posedge core_clk);
            fifo_data_ready <= 1'b1;
            #1;
            chk(iordy_oe_n, 1'b1, "iordy ready");
            host.hi(16'h0000);
        end
        rg_wr(8'h1f, 8'h00);
        for (int k = 0; k < 3; k++) begin
            rg_wr(8'h5b, (k < 2) ? 8'h80 : 8'h00);
            host.wr(2'b10, 3'h1, {15'h0, k != 1});
            #1;
            chk(xfer_mode.pio, k == 0, "pio from feature");
        end
        wrap_up();
    end
endmodule

`default_nettype wire
